/* core/csg_control.sv */
// Socket card-detect control and shared control register bank
// What this block does
// RULE_01: Detect change with resume drives ring low
// RULE_02: Ring stays low until status flag clears
// RULE_03: Resume enable bit 4, reset zero
// RULE_04: Detect control bits 3-2, 0 read zero
// RULE_05: Removal reset bit restores socket registers
// RULE_06: One shared control register for both sockets
// RULE_07: Shared control bits 7-5 read zero
// RULE_08: Bit 4 selects card B level mode
// RULE_09: Bit 3 selects card A level mode
// RULE_10: Bit 2 picks read-clear or write-one-clear
// RULE_11: Bit 1 selects status change level mode
// RULE_12: Power-down floats card outputs unless accessing
// RULE_13: Outputs float again after each access
// RULE_14: Interrupts still accepted during power-down
// RULE_15: Marked detect bits survive PCI reset with POWER_MGMT_EVENT
// RULE_16: Clear-mode, status-mode, power-down: global reset only
// RULE_17: Write-one clear of detect flag clears software request
// RULE_18: Edge pulses per event, level holds while set
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module csg_control #(
	parameter int ADDR_W = csg_pkg::AVS_ADDR_W
) (
	input  wire logic                           CLK_SYS,
	input  wire logic                           RST,
	input  wire logic                           PCI_RESET_PIN,
	input  wire logic                           POWER_MGMT_EVENT_EN,
	input  wire logic [ADDR_W-1:0]              AVS_ADDRESS,
	input  wire logic                           AVS_READ,
	input  wire logic                           AVS_WRITE,
	input  wire logic [csg_pkg::AVS_BE_W-1:0]   AVS_BYTEENABLE,
	input  wire logic [csg_pkg::AVS_DATA_W-1:0] AVS_WRITEDATA,
	output logic      [csg_pkg::AVS_DATA_W-1:0] AVS_READDATA,
	output logic                                AVS_WAITREQUEST,
	input  wire logic                           CARD_DETECT_INPUT_ONE,
	input  wire logic                           CARD_DETECT_INPUT_TWO,
	input  wire logic                           CARD_A_IREQ,
	input  wire logic                           CARD_B_IREQ,
	input  wire logic                           CARD_ACCESS_ACTIVE,
	output logic                                RING_INDICATE_OUTPUT,
	output logic                                HOST_IRQ_CARD_A,
	output logic                                HOST_IRQ_CARD_B,
	output logic                                HOST_IRQ_STATUS_CHANGE,
	output logic                                CARD_OUT_EN_N,
	output logic                                IRQ
);

	csg_pkg::csg_bus_state_type bus_state;

	// Control and status state
	logic                      detect_resume_enable;
	logic                      removal_reset_control;
	logic                      card_b_irq_level_select;
	logic                      card_a_irq_level_select;
	logic                      flag_clear_mode;
	logic                      status_change_irq_level_select;
	logic                      interface_power_down;
	logic                      detect_change_enable;
	logic                      card_status_change;
	logic                      software_detect_interrupt;
	logic [csg_pkg::INT_W-1:0] int_status;
	logic [csg_pkg::INT_W-1:0] int_mask;
	logic [1:0]                detect_prev;
	logic                      card_a_prev;
	logic                      card_b_prev;

	// Combinational helpers
	logic                      access;
	logic                      wr_go;
	logic                      rd_go;
	logic [7:0]                wbyte;
	logic [7:0]                rd_byte;
	logic [1:0]                detect_now;
	logic                      detect_change;
	logic                      card_removed;
	logic                      pci_clear;
	logic                      pme_clear;
	logic                      removal_clear;
	logic                      sw_request;
	logic                      csc_set;
	logic                      csc_clear;
	logic [csg_pkg::INT_W-1:0] int_set;
	logic [csg_pkg::INT_W-1:0] int_clear;
	logic                      next_ring;

	// A request is served in the cycle that waitrequest is low
	assign access = (bus_state == csg_pkg::BUS_ANSWER);
	assign wr_go  = access & AVS_WRITE & AVS_BYTEENABLE[0];
	assign rd_go  = access & AVS_READ;
	assign wbyte  = AVS_WRITEDATA[7:0];

	// PCI reset always clears plain bits; POWER_MGMT_EVENT context only without POWER_MGMT_EVENT
	assign pci_clear = PCI_RESET_PIN;
	assign pme_clear = PCI_RESET_PIN & ~POWER_MGMT_EVENT_EN; // RULE_15

	// Card detect pins are active low; present means both low
	assign detect_now    = {CARD_DETECT_INPUT_TWO, CARD_DETECT_INPUT_ONE};
	assign detect_change = (detect_now != detect_prev);
	assign card_removed  = (detect_prev == 2'h0) & (detect_now != 2'h0);
	assign removal_clear = card_removed & removal_reset_control; // RULE_05

	// Writing one to the software detect bit raises the detect flag while detect change is enabled
	assign sw_request = wr_go & (AVS_ADDRESS == csg_pkg::ADDR_DETECT_CTRL)
		& wbyte[csg_pkg::DC_SW_DETECT_BIT] & detect_change_enable;

	// Detect flag set from pins or software; set beats clear
	assign csc_set = (detect_change & detect_change_enable) | sw_request;

	// Clear by read or by write-one, chosen by the clear mode
	always_comb begin
		csc_clear = 1'b0;
		if (flag_clear_mode) begin
			csc_clear = wr_go
				& (AVS_ADDRESS == csg_pkg::ADDR_STATUS_CHANGE)
				& wbyte[csg_pkg::CSC_DETECT_BIT]; // RULE_10
		end else begin
			// Only the value that was actually returned is cleared
			csc_clear = rd_go
				& (AVS_ADDRESS == csg_pkg::ADDR_STATUS_CHANGE)
				& AVS_READDATA[csg_pkg::CSC_DETECT_BIT]; // RULE_10
		end
	end

	// Interrupt events; read clear removes only what was reported
	always_comb begin
		int_set = csg_pkg::INT_RESET;
		int_set[csg_pkg::INT_DETECT_BIT] = csc_set;
		int_set[csg_pkg::INT_CARD_A_BIT] = CARD_A_IREQ & ~card_a_prev; // RULE_14
		int_set[csg_pkg::INT_CARD_B_BIT] = CARD_B_IREQ & ~card_b_prev; // RULE_14
		int_clear = csg_pkg::INT_RESET;
		if (rd_go && (AVS_ADDRESS == csg_pkg::ADDR_INT_STATUS)) begin
			int_clear = AVS_READDATA[csg_pkg::INT_W-1:0];
		end
	end

	// Ring falls on a resumable detect change, rises on flag clear
	always_comb begin
		next_ring = RING_INDICATE_OUTPUT;
		if (detect_resume_enable && detect_change) begin
			next_ring = 1'b0; // RULE_01 RULE_03
		end else if (csc_clear) begin
			next_ring = 1'b1; // RULE_02
		end
	end

	// Read multiplexer; reserved bits and unmapped addresses read zero
	always_comb begin
		rd_byte = csg_pkg::REG_RESET;
		case (AVS_ADDRESS)
			csg_pkg::ADDR_STATUS_CHANGE: begin
				rd_byte[csg_pkg::CSC_DETECT_BIT] = card_status_change;
			end
			csg_pkg::ADDR_CHANGE_CONFIG: begin
				rd_byte[csg_pkg::CFG_DETECT_BIT] = detect_change_enable;
			end
			csg_pkg::ADDR_DETECT_CTRL: begin
				// Software detect bit is write-only and reads zero
				rd_byte[csg_pkg::DC_RESUME_BIT]  = detect_resume_enable;
				rd_byte[csg_pkg::DC_REMOVAL_BIT] = removal_reset_control; // RULE_04
			end
			csg_pkg::ADDR_SHARED_CTRL: begin
				rd_byte[csg_pkg::SC_B_LEVEL_BIT]    = card_b_irq_level_select;
				rd_byte[csg_pkg::SC_A_LEVEL_BIT]    = card_a_irq_level_select;
				rd_byte[csg_pkg::SC_FLAG_CLEAR_BIT] = flag_clear_mode;
				rd_byte[csg_pkg::SC_CSC_LEVEL_BIT]  =
					status_change_irq_level_select;
				rd_byte[csg_pkg::SC_POWER_DOWN_BIT] = interface_power_down; // RULE_07
			end
			csg_pkg::ADDR_INT_STATUS: begin
				rd_byte[csg_pkg::INT_W-1:0] = int_status;
			end
			csg_pkg::ADDR_INT_MASK: begin
				rd_byte[csg_pkg::INT_W-1:0] = int_mask;
			end
			default: begin
				rd_byte = csg_pkg::REG_RESET;
			end
		endcase
	end

	// Bus answer: one wait cycle, then waitrequest low for one cycle
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			bus_state       <= csg_pkg::BUS_IDLE;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			case (bus_state)
				csg_pkg::BUS_IDLE: begin
					if (AVS_READ || AVS_WRITE) begin
						bus_state       <= csg_pkg::BUS_ANSWER;
						AVS_WAITREQUEST <= 1'b0;
					end
				end
				csg_pkg::BUS_ANSWER: begin
					bus_state       <= csg_pkg::BUS_IDLE;
					AVS_WAITREQUEST <= 1'b1;
				end
				default: begin
					bus_state       <= csg_pkg::BUS_IDLE;
					AVS_WAITREQUEST <= 1'b1;
				end
			endcase
		end
	end

	// Read data is loaded as waitrequest falls, so it stands at accept
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			AVS_READDATA <= csg_pkg::DATA_RESET;
		end else if (bus_state == csg_pkg::BUS_IDLE && AVS_READ) begin
			AVS_READDATA <= 32'(rd_byte);
		end
	end

	// Per-socket detect control, context bits kept over PCI reset when POWER_MGMT_EVENT_EN is set
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			detect_resume_enable  <= 1'b0; // RULE_03
			removal_reset_control <= 1'b0;
		end else if (pme_clear) begin
			detect_resume_enable  <= 1'b0; // RULE_15
			removal_reset_control <= 1'b0; // RULE_15
		end else if (wr_go && AVS_ADDRESS == csg_pkg::ADDR_DETECT_CTRL) begin
			detect_resume_enable  <= wbyte[csg_pkg::DC_RESUME_BIT];
			removal_reset_control <= wbyte[csg_pkg::DC_REMOVAL_BIT]; // RULE_04
		end
	end

	// Shared control: one copy serves both sockets
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			card_b_irq_level_select <= 1'b0; // RULE_06
			card_a_irq_level_select <= 1'b0;
		end else if (pci_clear) begin
			card_b_irq_level_select <= 1'b0;
			card_a_irq_level_select <= 1'b0;
		end else if (wr_go && AVS_ADDRESS == csg_pkg::ADDR_SHARED_CTRL) begin
			card_b_irq_level_select <= wbyte[csg_pkg::SC_B_LEVEL_BIT]; // RULE_08
			card_a_irq_level_select <= wbyte[csg_pkg::SC_A_LEVEL_BIT]; // RULE_09
		end
	end

	// Bits that only the global reset clears; PCI reset leaves them
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			flag_clear_mode                <= 1'b0; // RULE_16
			status_change_irq_level_select <= 1'b0; // RULE_16
			interface_power_down           <= 1'b0; // RULE_16
		end else if (wr_go && AVS_ADDRESS == csg_pkg::ADDR_SHARED_CTRL) begin
			flag_clear_mode <= wbyte[csg_pkg::SC_FLAG_CLEAR_BIT]; // RULE_10
			status_change_irq_level_select <=
				wbyte[csg_pkg::SC_CSC_LEVEL_BIT]; // RULE_11
			interface_power_down <= wbyte[csg_pkg::SC_POWER_DOWN_BIT]; // RULE_12
		end
	end

	// Status change configuration, a socket register reset on removal
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			detect_change_enable <= 1'b0;
		end else if (pci_clear || removal_clear) begin
			detect_change_enable <= 1'b0; // RULE_05
		end else if (wr_go && AVS_ADDRESS == csg_pkg::ADDR_CHANGE_CONFIG) begin
			detect_change_enable <= wbyte[csg_pkg::CFG_DETECT_BIT];
		end
	end

	// Detect change flag; a set in the clearing cycle wins
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			card_status_change <= 1'b0;
		end else if (pme_clear) begin
			card_status_change <= 1'b0;
		end else if (csc_set) begin
			card_status_change <= 1'b1;
		end else if (csc_clear) begin
			card_status_change <= 1'b0; // RULE_10
		end
	end

	// Software request lives until its flag is cleared
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			software_detect_interrupt <= 1'b0;
		end else if (pme_clear) begin
			software_detect_interrupt <= 1'b0;
		end else if (sw_request) begin
			software_detect_interrupt <= 1'b1;
		end else if (csc_clear) begin
			software_detect_interrupt <= 1'b0; // RULE_17
		end
	end

	// Ring indicate idles high and is POWER_MGMT_EVENT context
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RING_INDICATE_OUTPUT <= 1'b1;
		end else if (pme_clear) begin
			RING_INDICATE_OUTPUT <= 1'b1;
		end else begin
			RING_INDICATE_OUTPUT <= next_ring;
		end
	end

	// Previous pin levels for change and edge detection
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			detect_prev <= 2'h0;
			card_a_prev <= 1'b0;
			card_b_prev <= 1'b0;
		end else begin
			detect_prev <= detect_now;
			card_a_prev <= CARD_A_IREQ;
			card_b_prev <= CARD_B_IREQ;
		end
	end

	// Sticky interrupt status; set wins over the read clear
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			int_status <= csg_pkg::INT_RESET;
		end else if (pci_clear) begin
			int_status <= csg_pkg::INT_RESET;
		end else begin
			int_status <= (int_status & ~int_clear) | int_set;
		end
	end

	// Interrupt mask, same layout as the status
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			int_mask <= csg_pkg::INT_RESET;
		end else if (pci_clear) begin
			int_mask <= csg_pkg::INT_RESET;
		end else if (wr_go && AVS_ADDRESS == csg_pkg::ADDR_INT_MASK) begin
			int_mask <= wbyte[csg_pkg::INT_W-1:0];
		end
	end

	// Interrupt level output; one cycle behind the status
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(int_status & int_mask);
		end
	end

	// Card outputs float in power-down except during an access
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			CARD_OUT_EN_N <= 1'b0;
		end else if (interface_power_down) begin
			CARD_OUT_EN_N <= ~CARD_ACCESS_ACTIVE; // RULE_12 RULE_13
		end else begin
			CARD_OUT_EN_N <= 1'b0;
		end
	end

	// Host interrupts keep running in power-down; one shaper each
	csg_irq_shaper u_irq_card_a (
		.clk        (CLK_SYS),
		.rst        (RST),
		.soft_clear (pci_clear),
		.level_mode (card_a_irq_level_select),
		.source     (CARD_A_IREQ), // RULE_09 RULE_14
		.host_irq   (HOST_IRQ_CARD_A)
	);

	csg_irq_shaper u_irq_card_b (
		.clk        (CLK_SYS),
		.rst        (RST),
		.soft_clear (pci_clear),
		.level_mode (card_b_irq_level_select),
		.source     (CARD_B_IREQ), // RULE_08 RULE_14
		.host_irq   (HOST_IRQ_CARD_B)
	);

	csg_irq_shaper u_irq_status (
		.clk        (CLK_SYS),
		.rst        (RST),
		.soft_clear (pme_clear),
		.level_mode (status_change_irq_level_select),
		.source     (card_status_change
			| software_detect_interrupt), // RULE_11 RULE_14 RULE_17
		.host_irq   (HOST_IRQ_STATUS_CHANGE)
	);

endmodule

/* core/csg_irq_shaper.sv */
// Host interrupt shaper: edge pulse or level per mode select
`timescale 1ns/1ps
module csg_irq_shaper (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic soft_clear,
	input  wire logic level_mode,
	input  wire logic source,
	output logic      host_irq
);

	logic source_prev;

	// Previous source level for rising-edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			source_prev <= 1'b0;
		end else if (soft_clear) begin
			source_prev <= 1'b0;
		end else begin
			source_prev <= source;
		end
	end

	// Level follows the source; edge gives one cycle per new event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_irq <= 1'b0;
		end else if (soft_clear) begin
			host_irq <= 1'b0;
		end else if (level_mode) begin
			host_irq <= source; // RULE_18
		end else begin
			host_irq <= source & ~source_prev; // RULE_18
		end
	end

endmodule

/* core/csg_pkg.sv */
// Package: register map, field positions, reset values and bus states
package csg_pkg;

	// Bus widths
	localparam int AVS_ADDR_W = 14;
	localparam int AVS_DATA_W = 32;
	localparam int AVS_BE_W   = 4;
	localparam int REG_W      = 8;
	localparam int INT_W      = 3;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_STATUS_CHANGE = 12'h804;
	localparam logic [11:0] IDX_CHANGE_CONFIG = 12'h805;
	localparam logic [11:0] IDX_DETECT_CTRL   = 12'h816;
	localparam logic [11:0] IDX_SHARED_CTRL   = 12'h81E;
	localparam logic [11:0] IDX_INT_STATUS    = 12'h880;
	localparam logic [11:0] IDX_INT_MASK      = 12'h881;

	// Byte addresses on the Avalon slave
	localparam logic [13:0] ADDR_STATUS_CHANGE = {IDX_STATUS_CHANGE, 2'h0};
	localparam logic [13:0] ADDR_CHANGE_CONFIG = {IDX_CHANGE_CONFIG, 2'h0};
	localparam logic [13:0] ADDR_DETECT_CTRL   = {IDX_DETECT_CTRL, 2'h0};
	localparam logic [13:0] ADDR_SHARED_CTRL   = {IDX_SHARED_CTRL, 2'h0};
	localparam logic [13:0] ADDR_INT_STATUS    = {IDX_INT_STATUS, 2'h0};
	localparam logic [13:0] ADDR_INT_MASK      = {IDX_INT_MASK, 2'h0};

	// Card detect and general control fields
	localparam int DC_SW_DETECT_BIT = 5;
	localparam int DC_RESUME_BIT    = 4;
	localparam int DC_REMOVAL_BIT   = 1;

	// Shared control fields
	localparam int SC_B_LEVEL_BIT    = 4;
	localparam int SC_A_LEVEL_BIT    = 3;
	localparam int SC_FLAG_CLEAR_BIT = 2;
	localparam int SC_CSC_LEVEL_BIT  = 1;
	localparam int SC_POWER_DOWN_BIT = 0;

	// Status change flag and its enable
	localparam int CSC_DETECT_BIT = 3;
	localparam int CFG_DETECT_BIT = 3;

	// Interrupt status and mask fields
	localparam int INT_DETECT_BIT = 0;
	localparam int INT_CARD_A_BIT = 1;
	localparam int INT_CARD_B_BIT = 2;

	// Reset values
	localparam logic [7:0]  REG_RESET  = 8'h00;
	localparam logic [2:0]  INT_RESET  = 3'h0;
	localparam logic [31:0] DATA_RESET = 32'h00000000;

	// Bus answer states, Gray coded
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'h0,
		BUS_ANSWER = 2'h1
	} csg_bus_state_type;

endpackage

/* sim/csg_card_model.sv */
// Card side model: detect pins, functional interrupts, access cycles
`timescale 1ns/1ps
module csg_card_model (
	input  wire logic       clk,
	input  wire logic       present,
	input  wire logic [1:0] irqs,
	input  wire logic       access,
	output logic            cd_one,
	output logic            cd_two,
	output logic [1:0]      ireq,
	output logic            active
);
	// Card seated at time zero, so both detect pins start low
	initial begin
		cd_one = 1'h0;
		cd_two = 1'h0;
		ireq = 2'h0;
		active = 1'h0;
	end

	// Pins move just after an edge, as a socket seen by the bus clock
	always @(posedge clk) begin
		cd_one <= !present;
		cd_two <= !present;
		ireq <= irqs;
		active <= access;
	end
endmodule

/* sim/csg_control_monitor.sv */
// Checker for the socket control bank, bound to its ports
`timescale 1ns/1ps
module csg_control_monitor #(
	parameter int ADDR_W = csg_pkg::AVS_ADDR_W
) (
	input wire logic              CLK_SYS,
	input wire logic              RST,
	input wire logic              PCI_RESET_PIN,
	input wire logic              POWER_MGMT_EVENT_EN,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic              AVS_READ,
	input wire logic              AVS_WRITE,
	input wire logic [3:0]        AVS_BYTEENABLE,
	input wire logic [31:0]       AVS_WRITEDATA,
	input wire logic [31:0]       AVS_READDATA,
	input wire logic              AVS_WAITREQUEST,
	input wire logic              CARD_DETECT_INPUT_ONE,
	input wire logic              CARD_DETECT_INPUT_TWO,
	input wire logic              CARD_A_IREQ,
	input wire logic              CARD_B_IREQ,
	input wire logic              CARD_ACCESS_ACTIVE,
	input wire logic              RING_INDICATE_OUTPUT,
	input wire logic              HOST_IRQ_CARD_A,
	input wire logic              HOST_IRQ_CARD_B,
	input wire logic              HOST_IRQ_STATUS_CHANGE,
	input wire logic              CARD_OUT_EN_N,
	input wire logic              IRQ
);
	logic [1:0] chg_hist;
	logic       cd_one_q;
	logic       cd_two_q;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	// Recent pin changes; two stages cover the ring's one-edge lag
	always_ff @(posedge CLK_SYS) begin
		cd_one_q <= CARD_DETECT_INPUT_ONE;
		cd_two_q <= CARD_DETECT_INPUT_TWO;
		chg_hist <= {chg_hist[0], (CARD_DETECT_INPUT_ONE != cd_one_q)
			|| (CARD_DETECT_INPUT_TWO != cd_two_q)};
	end

	chk_ring_cause: assert property (
		$fell(RING_INDICATE_OUTPUT) |-> |chg_hist)
		else $error("ring fell without a detect pin change");
	chk_ring_release: assert property (
		$rose(RING_INDICATE_OUTPUT) |-> $past(PCI_RESET_PIN)
		|| (!$past(AVS_WAITREQUEST) && ($past(AVS_READ) || $past(AVS_WRITE))))
		else $error("ring rose without a register access");
	chk_wait_one: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request not answered after one wait cycle");
	chk_wait_single: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	chk_detect_reserved_bits: assert property (
		AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == csg_pkg::ADDR_DETECT_CTRL
		|=> AVS_READDATA[3:2] == 2'h0 && AVS_READDATA[0] == 1'h0)
		else $error("reserved detect control bits read nonzero");
	chk_shared_reserved_bits: assert property (
		AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == csg_pkg::ADDR_SHARED_CTRL
		|=> AVS_READDATA[7:5] == 3'h0)
		else $error("reserved shared control bits read nonzero");
	chk_access_drives: assert property (
		CARD_ACCESS_ACTIVE |=> !CARD_OUT_EN_N)
		else $error("card outputs floated during an access");
	chk_float_after: assert property (
		$rose(CARD_OUT_EN_N) |-> !$past(CARD_ACCESS_ACTIVE))
		else $error("card outputs floated while access active");
	chk_pd_keeps: assert property (
		PCI_RESET_PIN && CARD_OUT_EN_N && !CARD_ACCESS_ACTIVE |=> CARD_OUT_EN_N)
		else $error("PCI reset left power-down mode");
	chk_irq_a_cause: assert property (
		HOST_IRQ_CARD_A |-> $past(CARD_A_IREQ))
		else $error("card A host interrupt without request");
	chk_irq_b_cause: assert property (
		HOST_IRQ_CARD_B |-> $past(CARD_B_IREQ))
		else $error("card B host interrupt without request");

	cov_ring: cover property ($fell(RING_INDICATE_OUTPUT));
	cov_float: cover property ($rose(CARD_OUT_EN_N));
	cov_irq: cover property ($rose(IRQ));
endmodule

bind csg_control csg_control_monitor #(.ADDR_W(ADDR_W)) csg_control_monitor_inst (
	.CLK_SYS(CLK_SYS), .RST(RST), .PCI_RESET_PIN(PCI_RESET_PIN),
	.POWER_MGMT_EVENT_EN(POWER_MGMT_EVENT_EN), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.CARD_DETECT_INPUT_ONE(CARD_DETECT_INPUT_ONE),
	.CARD_DETECT_INPUT_TWO(CARD_DETECT_INPUT_TWO),
	.CARD_A_IREQ(CARD_A_IREQ), .CARD_B_IREQ(CARD_B_IREQ),
	.CARD_ACCESS_ACTIVE(CARD_ACCESS_ACTIVE),
	.RING_INDICATE_OUTPUT(RING_INDICATE_OUTPUT),
	.HOST_IRQ_CARD_A(HOST_IRQ_CARD_A), .HOST_IRQ_CARD_B(HOST_IRQ_CARD_B),
	.HOST_IRQ_STATUS_CHANGE(HOST_IRQ_STATUS_CHANGE),
	.CARD_OUT_EN_N(CARD_OUT_EN_N), .IRQ(IRQ));

/* sim/testbench.sv */
// Self-checking bench for the socket control bank
`timescale 1ns/1ps
module testbench;
	localparam logic [13:0] CS = csg_pkg::ADDR_STATUS_CHANGE;
	localparam logic [13:0] CC = csg_pkg::ADDR_CHANGE_CONFIG;
	localparam logic [13:0] DC = csg_pkg::ADDR_DETECT_CTRL;
	localparam logic [13:0] SC = csg_pkg::ADDR_SHARED_CTRL;
	localparam logic [13:0] IS = csg_pkg::ADDR_INT_STATUS;
	localparam logic [13:0] IM = csg_pkg::ADDR_INT_MASK;
	logic        clk_sys = 1'h0;
	logic        rst = 1'h1;
	logic        pci_rst = 1'h0;
	logic        pme_en = 1'h0;
	logic [13:0] address = 14'h0000;
	logic        read = 1'h0;
	logic        write = 1'h0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic        waitreq;
	logic        present = 1'h1;
	logic [1:0]  irqs = 2'h0;
	logic        access = 1'h0;
	logic        cd_one;
	logic        cd_two;
	logic [1:0]  ireq;
	logic        active;
	logic        ring;
	logic [1:0]  host;
	logic        host_csc;
	logic        out_en_n;
	logic        irq;
	logic [7:0]  q;
	logic [7:0]  cnt;
	int          miscompares = 0;
	int          n_tests = 0;

	csg_control csg_control_inst (.CLK_SYS(clk_sys), .RST(rst),
		.PCI_RESET_PIN(pci_rst), .POWER_MGMT_EVENT_EN(pme_en),
		.AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write),
		.AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .CARD_DETECT_INPUT_ONE(cd_one),
		.CARD_DETECT_INPUT_TWO(cd_two), .CARD_A_IREQ(ireq[0]),
		.CARD_B_IREQ(ireq[1]), .CARD_ACCESS_ACTIVE(active),
		.RING_INDICATE_OUTPUT(ring), .HOST_IRQ_CARD_A(host[0]),
		.HOST_IRQ_CARD_B(host[1]), .HOST_IRQ_STATUS_CHANGE(host_csc),
		.CARD_OUT_EN_N(out_en_n), .IRQ(irq));
	csg_card_model csg_card_model_inst (.clk(clk_sys), .present(present),
		.irqs(irqs), .access(access), .cd_one(cd_one), .cd_two(cd_two),
		.ireq(ireq), .active(active));

	// Free-running bus clock
	initial begin
		forever #50 clk_sys = !clk_sys;
	end

	task automatic close_out();
		$display("Counts: %0d compared, %0d mismatched", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask

	// One access; the request is held until waitrequest is seen low
	task automatic bus(input logic rd, input logic [13:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		address <= a;
		wdata <= {24'h000000, d};
		read <= rd;
		write <= !rd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitreq !== 1'h0 && n < 20);
		q = rdata[7:0];
		read <= 1'h0;
		write <= 1'h0;
		if (waitreq !== 1'h0) begin
			$display("ERROR bus wait expected 0 seen %b", waitreq);
			miscompares++;
			close_out();
		end
	endtask

	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		bus(1'h0, a, d);
	endtask

	task automatic rc(input logic [13:0] a, input logic [7:0] exp,
		input string nm);
		bus(1'h1, a, 8'h00);
		chk(nm, exp, q);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Hang guard
	initial begin
		tick(5000);
		$display("ERROR timeout expected done seen running");
		miscompares++;
		close_out();
	end

	// Main sequence
	initial begin
		tick(20);
		rst <= 1'h0;
		rc(SC, 8'h00, "shared");
		rc(DC, 8'h00, "detect");
		rc(14'h0FFC, 8'h00, "unmapped");
		wr(SC, 8'hFE);
		rc(SC, 8'h1E, "shared");
		wr(DC, 8'hFF);
		rc(DC, 8'h12, "detect");
		$display("test registers done");
		// Level mode follows the request, edge mode pulses once
		wr(SC, 8'h18);
		for (int i = 0; i < 2; i++) begin
			irqs[i] <= 1'h1;
			tick(4);
			chk("host level", 8'h01, {7'h00, host[i]});
			irqs[i] <= 1'h0;
			tick(4);
		end
		wr(SC, 8'h00);
		for (int i = 0; i < 2; i++) begin
			cnt = 8'h00;
			irqs[i] <= 1'h1;
			repeat (8) begin
				@(posedge clk_sys);
				cnt = cnt + {7'h00, host[i]};
			end
			chk("host pulses", 8'h01, cnt);
			irqs[i] <= 1'h0;
		end
		chk("irq masked", 8'h00, {7'h00, irq});
		rc(IS, 8'h06, "int status");
		wr(IM, 8'h02);
		irqs[0] <= 1'h1;
		tick(4);
		chk("irq", 8'h01, {7'h00, irq});
		rc(IS, 8'h02, "int status");
		irqs[0] <= 1'h0;
		tick(3);
		chk("irq", 8'h00, {7'h00, irq});
		$display("test interrupts done");
		// Removal with resume on, read-clear mode
		wr(CC, 8'h08);
		wr(DC, 8'h10);
		present <= 1'h0;
		tick(4);
		chk("ring", 8'h00, {7'h00, ring});
		rc(CS, 8'h08, "status change");
		tick(2);
		chk("ring", 8'h01, {7'h00, ring});
		rc(CS, 8'h00, "status change");
		rc(CC, 8'h08, "change config");
		// Resume off leaves ring alone; removal reset clears config
		wr(DC, 8'h02);
		present <= 1'h1;
		tick(4);
		chk("ring", 8'h01, {7'h00, ring});
		rc(CS, 8'h08, "status change");
		present <= 1'h0;
		tick(4);
		rc(CC, 8'h00, "change config");
		bus(1'h1, CS, 8'h00);
		$display("test resume done");
		// Write-one clear mode
		wr(CC, 8'h08);
		wr(DC, 8'h10);
		wr(SC, 8'h06);
		present <= 1'h1;
		tick(4);
		rc(CS, 8'h08, "status change");
		rc(CS, 8'h08, "status change");
		chk("ring", 8'h00, {7'h00, ring});
		chk("host csc", 8'h01, {7'h00, host_csc});
		wr(CS, 8'h08);
		tick(2);
		chk("ring", 8'h01, {7'h00, ring});
		chk("host csc", 8'h00, {7'h00, host_csc});
		wr(DC, 8'h30);
		rc(CS, 8'h08, "status change");
		wr(CS, 8'h08);
		rc(CS, 8'h00, "status change");
		$display("test write clear done");
		// Power-down: outputs float except during an access
		bus(1'h1, IS, 8'h00);
		wr(SC, 8'h01);
		tick(3);
		chk("float", 8'h01, {7'h00, out_en_n});
		access <= 1'h1;
		tick(3);
		chk("float", 8'h00, {7'h00, out_en_n});
		access <= 1'h0;
		irqs[0] <= 1'h1;
		tick(3);
		chk("float", 8'h01, {7'h00, out_en_n});
		irqs[0] <= 1'h0;
		rc(IS, 8'h02, "int status");
		// PCI reset with and without power management events
		wr(SC, 8'h1F);
		wr(DC, 8'h12);
		pme_en <= 1'h1;
		pci_rst <= 1'h1;
		tick(2);
		pci_rst <= 1'h0;
		chk("float", 8'h01, {7'h00, out_en_n});
		rc(SC, 8'h07, "shared");
		rc(DC, 8'h12, "detect");
		pme_en <= 1'h0;
		pci_rst <= 1'h1;
		tick(2);
		pci_rst <= 1'h0;
		rc(DC, 8'h00, "detect");
		$display("test power down done");
		close_out();
	end
endmodule
